// >>> include/lmar_defs.vh
// Constants for the local memory access router: register map, fields, resets.
// Assumes inclusion by the router module and its test bench; definitions only.
`ifndef LMAR_DEFS_VH
`define LMAR_DEFS_VH

// Register byte offsets
`define LMAR_REG_REGION   8'h00
`define LMAR_REG_CTRL     8'h04
`define LMAR_REG_STATUS   8'h08
`define LMAR_REG_FAULT    8'h0c
`define LMAR_REG_COUNT    8'h10

// Region setting field layout (4 bits per region)
`define LMAR_RGN_W        4
`define LMAR_RGN_ALLOW    0
`define LMAR_RGN_CACHE    1
`define LMAR_RGN_WBACK    2
`define LMAR_REGION_RESET 32'h1111_1111

// Control register fields
`define LMAR_CTRL_WB      0
`define LMAR_CTRL_CLRF    1
`define LMAR_CTRL_RESET   32'h0000_0000

// Region select: top three address bits
`define LMAR_RGN_HI       31
`define LMAR_RGN_LO       29

// Target codes
`define LMAR_TGT_EXT      3'h0
`define LMAR_TGT_IRAM     3'h1
`define LMAR_TGT_IROM     3'h2
`define LMAR_TGT_DRAM     3'h3
`define LMAR_TGT_DROM     3'h4
`define LMAR_TGT_FLP      3'h5
`define LMAR_TGT_CACHE    3'h6

// AXI responses
`define LMAR_RESP_OK      2'h0
`define LMAR_RESP_SLVERR  2'h2

`endif

// >>> logic/lmar_router.v
// Local memory access router: decodes fetch, load and store addresses,
// checks caches and region protection, and drives refill and replay.
// Assumes a single 10 MHz clock; tag and data arrays answer combinationally.
`timescale 1ns/1ps
`include "lmar_defs.vh"

module lmar_router #(
  parameter        NUM_LSU    = 1,
  parameter        DC_WAYS    = 2,
  parameter        IC_WAYS    = 1,
  parameter        N_IRAM     = 1,
  parameter        N_DRAM     = 1,
  parameter        HAS_IROM   = 0,
  parameter        HAS_DROM   = 0,
  parameter        HAS_FLP    = 1,
  parameter        IDX_W      = 6,
  parameter        TAG_W      = 20,
  parameter [31:0] IRAM_BASE  = 32'h4000_0000,
  parameter [31:0] IRAM_MASK  = 32'hffff_0000,
  parameter [31:0] IROM_BASE  = 32'h4010_0000,
  parameter [31:0] IROM_MASK  = 32'hffff_0000,
  parameter [31:0] DRAM_BASE  = 32'h3ff0_0000,
  parameter [31:0] DRAM_MASK  = 32'hffff_0000,
  parameter [31:0] DROM_BASE  = 32'h3fe0_0000,
  parameter [31:0] DROM_MASK  = 32'hffff_0000,
  parameter [31:0] FLP_BASE   = 32'h3fd0_0000,
  parameter [31:0] FLP_MASK   = 32'hfff0_0000
) (
  // Clock and reset
  input  wire                   aclk,
  input  wire                   aresetn,
  // AXI4-Lite write address and data
  input  wire [7:0]             s_axi_awaddr,
  input  wire                   s_axi_awvalid,
  output reg                    s_axi_awready,
  input  wire [31:0]            s_axi_wdata,
  input  wire [3:0]             s_axi_wstrb,
  input  wire                   s_axi_wvalid,
  output reg                    s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]             s_axi_bresp,
  output reg                    s_axi_bvalid,
  input  wire                   s_axi_bready,
  // AXI4-Lite read
  input  wire [7:0]             s_axi_araddr,
  input  wire                   s_axi_arvalid,
  output reg                    s_axi_arready,
  output reg  [31:0]            s_axi_rdata,
  output reg  [1:0]             s_axi_rresp,
  output reg                    s_axi_rvalid,
  input  wire                   s_axi_rready,
  // Fetch request
  input  wire                   fetch_valid,
  input  wire [31:0]            fetch_addr,
  // Load/store request (shared by all units)
  input  wire                   ls_valid,
  input  wire                   ls_store,
  input  wire                   ls_word,
  input  wire [31:0]            ls_addr,
  // Cache tag array read data, one entry per way
  input  wire [4*TAG_W-1:0]     ic_tag_rd,
  input  wire [3:0]             ic_tag_vld,
  input  wire [4*(TAG_W+3)-1:0] dc_tag_rd,
  input  wire [3:0]             dc_tag_vld,
  // Refill completion from external memory
  input  wire                   refill_done,
  // Target selects and cache indices
  output reg  [2:0]             fetch_target,
  output reg  [2:0]             ls_target,
  output reg  [IDX_W-1:0]       ic_index,
  output reg  [IDX_W-1:0]       dc_index,
  output reg  [3:0]             ic_way_hit,
  output reg  [3:0]             dc_way_hit,
  output reg                    dc_wr_dirty,
  // Refill request
  output reg                    refill_req,
  output reg  [31:0]            refill_addr,
  // Pipeline control
  output reg                    replay,
  output reg                    replay_next,
  output reg                    prot_fault,
  output reg                    fetch_fault
);

  // Two aligned windows are apart when they differ on a bit both masks keep
  function lmar_apart;
    input [31:0] ba;
    input [31:0] ma;
    input [31:0] bb;
    input [31:0] mb;
    begin
      lmar_apart = ((ba ^ bb) & ma & mb) != 32'h0;
    end
  endfunction

  // Configuration sanity: folded into a constant ok flag
  localparam CFG_OK = (IC_WAYS <= 4) && (DC_WAYS <= 4)
    && (DC_WAYS + N_DRAM + HAS_DROM + HAS_FLP <= 4)
    && ((IC_WAYS > 0 ? 1 : 0) + N_IRAM + HAS_IROM <= 4)
    && (N_IRAM <= 2) && (N_DRAM <= 2) && (HAS_IROM <= 1) && (HAS_DROM <= 1)
    && (HAS_FLP <= 1)
    && (NUM_LSU == 1 || DC_WAYS == 0)
    && (DC_WAYS + N_DRAM + HAS_DROM + HAS_FLP >= 1)
    && (IC_WAYS + N_IRAM + HAS_IROM >= 1)
    && ((IRAM_BASE & ~IRAM_MASK) == 32'h0) && ((DRAM_BASE & ~DRAM_MASK) == 32'h0)
    && ((FLP_BASE & ~FLP_MASK) == 32'h0)
    && ((IROM_BASE & ~IROM_MASK) == 32'h0) && ((DROM_BASE & ~DROM_MASK) == 32'h0)
    && lmar_apart(IRAM_BASE, IRAM_MASK, IROM_BASE, IROM_MASK)
    && lmar_apart(IRAM_BASE, IRAM_MASK, DRAM_BASE, DRAM_MASK)
    && lmar_apart(IRAM_BASE, IRAM_MASK, FLP_BASE, FLP_MASK)
    && lmar_apart(DRAM_BASE, DRAM_MASK, DROM_BASE, DROM_MASK)
    && lmar_apart(DRAM_BASE, DRAM_MASK, FLP_BASE, FLP_MASK)
    && lmar_apart(DROM_BASE, DROM_MASK, FLP_BASE, FLP_MASK);

  localparam OFF_W = 32 - TAG_W - IDX_W;

  // Registers
  reg [31:0] region_r;
  reg [31:0] ctrl_r;
  reg [31:0] fault_addr_r;
  reg [15:0] miss_cnt_r;
  reg [15:0] fault_cnt_r;
  reg        refill_busy_r;
  reg        aw_held_r;
  reg        w_held_r;
  reg [7:0]  aw_addr_r;
  reg [31:0] w_data_r;
  reg [3:0]  w_strb_r;

  // Address decode: ranges are disjoint so at most one matches
  function [2:0] lmar_decode;
    input [31:0] a;
    input        is_fetch;
    begin
      lmar_decode = `LMAR_TGT_EXT;
      if (is_fetch) begin
        if (N_IRAM > 0 && (a & IRAM_MASK) == IRAM_BASE)
          lmar_decode = `LMAR_TGT_IRAM;
        else if (HAS_IROM != 0 && (a & IROM_MASK) == IROM_BASE)
          lmar_decode = `LMAR_TGT_IROM;
      end else begin
        if (N_IRAM > 0 && (a & IRAM_MASK) == IRAM_BASE)
          lmar_decode = `LMAR_TGT_IRAM;
        else if (HAS_IROM != 0 && (a & IROM_MASK) == IROM_BASE)
          lmar_decode = `LMAR_TGT_IROM;
        else if (N_DRAM > 0 && (a & DRAM_MASK) == DRAM_BASE)
          lmar_decode = `LMAR_TGT_DRAM;
        else if (HAS_DROM != 0 && (a & DROM_MASK) == DROM_BASE)
          lmar_decode = `LMAR_TGT_DROM;
        else if (HAS_FLP != 0 && (a & FLP_MASK) == FLP_BASE)
          lmar_decode = `LMAR_TGT_FLP;
      end
    end
  endfunction

  // Region setting of an address
  function [3:0] lmar_region;
    input [31:0] a;
    input [31:0] r;
    begin
      lmar_region = r[a[`LMAR_RGN_HI:`LMAR_RGN_LO]*`LMAR_RGN_W +: `LMAR_RGN_W];
    end
  endfunction

  // Way hit vector: physical tag match against stored tags
  function [3:0] lmar_hits;
    input [4*TAG_W-1:0] tags;
    input [3:0]         vld;
    input [TAG_W-1:0]   ptag;
    input integer       ways;
    integer k;
    begin
      lmar_hits = 4'h0;
      for (k = 0; k < 4; k = k + 1)
        if (k < ways && vld[k] && tags[k*TAG_W +: TAG_W] == ptag)
          lmar_hits[k] = 1'b1;
    end
  endfunction

  // Combinational evaluation; address used as physical directly
  wire [3:0]       f_rgn   = lmar_region(fetch_addr, region_r);
  wire [3:0]       l_rgn   = lmar_region(ls_addr, region_r);
  wire [2:0]       f_loc   = lmar_decode(fetch_addr, 1'b1);
  wire [2:0]       l_loc   = lmar_decode(ls_addr, 1'b0);
  wire             f_cach  = f_rgn[`LMAR_RGN_CACHE] && IC_WAYS > 0;
  wire             l_cach  = l_rgn[`LMAR_RGN_CACHE] && DC_WAYS > 0;
  wire [2:0]       f_tgt   = (f_loc == `LMAR_TGT_EXT && f_cach) ? `LMAR_TGT_CACHE : f_loc;
  wire [2:0]       l_tgt   = (l_loc == `LMAR_TGT_EXT && l_cach) ? `LMAR_TGT_CACHE : l_loc;
  wire [TAG_W-1:0] f_ptag  = fetch_addr[31 -: TAG_W];
  wire [TAG_W-1:0] l_ptag  = ls_addr[31 -: TAG_W];
  wire [4*TAG_W-1:0] dc_tags;
  wire [3:0]       f_hit   = lmar_hits(ic_tag_rd, ic_tag_vld, f_ptag, IC_WAYS);
  wire [3:0]       l_hit   = lmar_hits(dc_tags, dc_tag_vld, l_ptag, DC_WAYS);
  wire             f_deny  = fetch_valid && !f_rgn[`LMAR_RGN_ALLOW];
  wire             l_deny  = ls_valid && !l_rgn[`LMAR_RGN_ALLOW];
  wire             f_miss  = fetch_valid && !f_deny && f_tgt == `LMAR_TGT_CACHE
                             && f_hit == 4'h0;
  wire             l_miss  = ls_valid && !l_deny && !ls_store
                             && l_tgt == `LMAR_TGT_CACHE && l_hit == 4'h0;
  wire             l_imem  = ls_valid && !l_deny && ls_word
                             && (l_loc == `LMAR_TGT_IRAM || l_loc == `LMAR_TGT_IROM);
  wire             wback   = l_rgn[`LMAR_RGN_WBACK] && ctrl_r[`LMAR_CTRL_WB];

  // Data tag entry: {lock, replace, dirty, tag}; only the tag is compared
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_tag
      assign dc_tags[g*TAG_W +: TAG_W] = dc_tag_rd[g*(TAG_W+3) +: TAG_W];
    end
  endgenerate

  // Access path outputs
  always @(posedge aclk) begin
    if (!aresetn) begin
      fetch_target  <= `LMAR_TGT_EXT;
      ls_target     <= `LMAR_TGT_EXT;
      ic_index      <= {IDX_W{1'b0}};
      dc_index      <= {IDX_W{1'b0}};
      ic_way_hit    <= 4'h0;
      dc_way_hit    <= 4'h0;
      dc_wr_dirty   <= 1'b0;
      refill_req    <= 1'b0;
      refill_addr   <= 32'h0;
      refill_busy_r <= 1'b0;
      replay        <= 1'b0;
      replay_next   <= 1'b0;
      prot_fault    <= 1'b0;
      fetch_fault   <= 1'b0;
      fault_addr_r  <= 32'h0;
      miss_cnt_r    <= 16'h0;
      fault_cnt_r   <= 16'h0;
    end else begin
      fetch_target <= f_tgt;
      ls_target    <= l_tgt;
      ic_index     <= fetch_addr[OFF_W +: IDX_W];
      dc_index     <= ls_addr[OFF_W +: IDX_W];
      ic_way_hit   <= (fetch_valid && f_tgt == `LMAR_TGT_CACHE) ? f_hit : 4'h0;
      dc_way_hit   <= (ls_valid && l_tgt == `LMAR_TGT_CACHE) ? l_hit : 4'h0;
      dc_wr_dirty  <= ls_valid && ls_store && l_tgt == `LMAR_TGT_CACHE
                      && l_hit != 4'h0 && wback;
      prot_fault   <= l_deny;
      fetch_fault  <= f_deny;
      replay       <= l_imem && !ls_store || f_miss || l_miss;
      replay_next  <= l_imem && ls_store;
      refill_req   <= 1'b0;
      if (refill_busy_r) begin
        if (refill_done)
          refill_busy_r <= 1'b0;
      end else if (l_miss || f_miss) begin
        refill_req    <= 1'b1;
        refill_busy_r <= 1'b1;
        refill_addr   <= l_miss ? {ls_addr[31:OFF_W], {OFF_W{1'b0}}}
                                : {fetch_addr[31:OFF_W], {OFF_W{1'b0}}};
        miss_cnt_r    <= miss_cnt_r + 16'h1;
      end
      if (l_deny || f_deny) begin
        fault_addr_r <= l_deny ? ls_addr : fetch_addr;
        fault_cnt_r  <= fault_cnt_r + 16'h1;
      end else if (ctrl_r[`LMAR_CTRL_CLRF]) begin
        fault_cnt_r  <= 16'h0;
      end
    end
  end

  // AXI4-Lite write side: address and data taken in either order
  function [31:0] lmar_merge;
    input [31:0] old;
    input [31:0] d;
    input [3:0]  s;
    integer b;
    begin
      lmar_merge = old;
      for (b = 0; b < 4; b = b + 1)
        if (s[b])
          lmar_merge[b*8 +: 8] = d[b*8 +: 8];
    end
  endfunction

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `LMAR_RESP_OK;
      aw_held_r     <= 1'b0;
      w_held_r      <= 1'b0;
      aw_addr_r     <= 8'h0;
      w_data_r      <= 32'h0;
      w_strb_r      <= 4'h0;
      region_r      <= `LMAR_REGION_RESET;
      ctrl_r        <= `LMAR_CTRL_RESET;
    end else begin
      s_axi_awready <= !aw_held_r && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready  <= !w_held_r && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      ctrl_r[`LMAR_CTRL_CLRF] <= 1'b0;
      if (aw_held_r && w_held_r && !s_axi_bvalid) begin
        aw_held_r    <= 1'b0;
        w_held_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `LMAR_RESP_OK;
        case (aw_addr_r)
          `LMAR_REG_REGION: region_r <= lmar_merge(region_r, w_data_r, w_strb_r);
          `LMAR_REG_CTRL: ctrl_r <= lmar_merge(ctrl_r, w_data_r, w_strb_r) & 32'h0000_0003;
          `LMAR_REG_STATUS, `LMAR_REG_FAULT, `LMAR_REG_COUNT: ;
          default:        s_axi_bresp <= `LMAR_RESP_SLVERR;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // AXI4-Lite read side
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= `LMAR_RESP_OK;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= `LMAR_RESP_OK;
        case (s_axi_araddr)
          `LMAR_REG_REGION: s_axi_rdata <= region_r;
          `LMAR_REG_CTRL:   s_axi_rdata <= ctrl_r;
          `LMAR_REG_STATUS: s_axi_rdata <= {28'h0, CFG_OK ? 1'b1 : 1'b0,
                                            fetch_fault, prot_fault, refill_busy_r};
          `LMAR_REG_FAULT:  s_axi_rdata <= fault_addr_r;
          `LMAR_REG_COUNT:  s_axi_rdata <= {fault_cnt_r, miss_cnt_r};
          default: begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `LMAR_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // lmar_router

// >>> test/lmar_monitor.sv
// Checker for the router's access path: replay, targets, indices, hits, faults.
// Assumes it is bound into the router and sees only the router's ports.
`timescale 1ns/1ps
module lmar_monitor #(
  parameter        TAG_W     = 20,
  parameter        IDX_W     = 6,
  parameter [31:0] IRAM_BASE = 32'h4000_0000,
  parameter [31:0] IRAM_MASK = 32'hffff_0000
) (
  // Clock and reset
  input wire                   aclk,
  input wire                   aresetn,
  // Requests and tag answers
  input wire                   fetch_valid,
  input wire [31:0]            fetch_addr,
  input wire                   ls_valid,
  input wire                   ls_store,
  input wire                   ls_word,
  input wire [31:0]            ls_addr,
  input wire [4*(TAG_W+3)-1:0] dc_tag_rd,
  input wire [3:0]             dc_tag_vld,
  input wire [4*TAG_W-1:0]     ic_tag_rd,
  input wire [3:0]             ic_tag_vld,
  // Router answers
  input wire [2:0]             ls_target,
  input wire [2:0]             fetch_target,
  input wire [3:0]             ic_way_hit,
  input wire [IDX_W-1:0]       ic_index,
  input wire [IDX_W-1:0]       dc_index,
  input wire [3:0]             dc_way_hit,
  input wire                   refill_req,
  input wire [31:0]            refill_addr,
  input wire                   replay,
  input wire                   replay_next,
  input wire                   prot_fault,
  input wire                   fetch_fault
);
  localparam OFF = 32 - TAG_W - IDX_W;
  wire             iram = (ls_addr & IRAM_MASK) == IRAM_BASE;
  wire [IDX_W-1:0] di   = ls_addr[OFF+:IDX_W];
  wire [IDX_W-1:0] fi   = fetch_addr[OFF+:IDX_W];
  wire [TAG_W-1:0] pt   = ls_addr[31-:TAG_W];
  wire [1:0]       hv   = {dc_tag_vld[1] && dc_tag_rd[TAG_W+3+:TAG_W] == pt,
                           dc_tag_vld[0] && dc_tag_rd[0+:TAG_W] == pt};
  wire             fh   = ic_tag_vld[0] && ic_tag_rd[0+:TAG_W] == fetch_addr[31-:TAG_W];
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  load_replay_a: assert property (
    ls_valid && !ls_store && ls_word && iram |=> replay) else $error("load not replayed");
  store_replay_a: assert property (
    ls_valid && ls_store && ls_word && iram |=> replay_next) else $error("store not replayed");
  iram_target_a: assert property (
    ls_valid && iram |=> ls_target == 3'h1) else $error("wrong target for iram");
  dc_index_a: assert property (
    ls_valid |=> dc_index == $past(di)) else $error("data index wrong");
  ic_index_a: assert property (
    fetch_valid |=> ic_index == $past(fi)) else $error("fetch index wrong");
  way_hit_a: assert property (
    $past(ls_valid) && ls_target == 3'h6 |-> dc_way_hit[1:0] == $past(hv))
    else $error("way hit wrong");
  miss_replay_a: assert property (
    ls_target == 3'h6 && dc_way_hit == 4'h0 && $past(ls_valid) && !$past(ls_store) |-> replay)
    else $error("read miss not replayed");
  line_align_a: assert property (
    refill_req |-> refill_addr[OFF-1:0] == '0) else $error("refill not line aligned");
  store_norefill_a: assert property (
    ls_valid && ls_store && !fetch_valid |=> !refill_req) else $error("store refilled");
  fault_cause_a: assert property (
    prot_fault |-> $past(ls_valid)) else $error("fault without access");
  fetch_cause_a: assert property (
    fetch_fault |-> $past(fetch_valid)) else $error("fetch fault without fetch");
  fetch_target_a: assert property (
    (fetch_addr & IRAM_MASK) == IRAM_BASE |=> fetch_target == 3'h1)
    else $error("wrong fetch target");
  fetch_hit_a: assert property (
    $past(fetch_valid) && fetch_target == 3'h6 |-> ic_way_hit[0] == $past(fh))
    else $error("fetch way hit wrong");
endmodule // lmar_monitor

// >>> test/lmar_far_model.sv
// Far-side model: two-way data cache tag array and the external refill path.
// Assumes tags answer the live load/store address; refills install ways in turn.
`timescale 1ns/1ps
module lmar_far_model #(
  parameter TAG_W = 20,
  parameter IDX_W = 6
) (
  // Clock and reset
  input  wire                   aclk,
  input  wire                   aresetn,
  // Lookup and refill request
  input  wire [31:0]            ls_addr,
  input  wire                   refill_req,
  input  wire [31:0]            refill_addr,
  input  wire [3:0]             delay,
  // Tag answers and completion
  output reg  [4*(TAG_W+3)-1:0] dc_tag_rd,
  output reg  [3:0]             dc_tag_vld,
  output reg                    refill_done
);
  localparam OFF = 32 - TAG_W - IDX_W;
  reg [TAG_W-1:0]  tag_r [0:1][0:(1<<IDX_W)-1];
  reg              vld_r [0:1][0:(1<<IDX_W)-1];
  reg [3:0]        cnt_r;
  reg [31:0]       line_r;
  reg              busy_r, vic_r;
  integer          k;
  wire [IDX_W-1:0] di = ls_addr[OFF+:IDX_W];
  // Lookup answered every cycle; absent ways show a tag that never matches
  always_comb begin
    dc_tag_rd = {4{3'b000, ~ls_addr[31-:TAG_W]}};
    dc_tag_rd[0+:TAG_W] = tag_r[0][di];
    dc_tag_rd[TAG_W+3+:TAG_W] = tag_r[1][di];
    dc_tag_vld = {2'b00, vld_r[1][di], vld_r[0][di]};
  end
  always @(posedge aclk) begin
    refill_done <= 1'b0;
    if (!aresetn) begin
      busy_r <= 1'b0;
      vic_r <= 1'b0;
      for (k = 0; k < (1<<IDX_W); k = k + 1) begin
        vld_r[0][k] <= 1'b0;
        vld_r[1][k] <= 1'b0;
      end
    end else if (refill_req && !busy_r) begin
      busy_r <= 1'b1;
      cnt_r <= delay;
      line_r <= refill_addr;
    end else if (busy_r && cnt_r != 4'h0) begin
      cnt_r <= cnt_r - 4'h1;
    end else if (busy_r) begin
      busy_r <= 1'b0;
      refill_done <= 1'b1;
      vic_r <= ~vic_r;
      tag_r[vic_r][line_r[OFF+:IDX_W]] <= line_r[31-:TAG_W];
      vld_r[vic_r][line_r[OFF+:IDX_W]] <= 1'b1;
    end
  end
endmodule // lmar_far_model

// >>> test/lmar_router_test.sv
// Self-checking bench for the local memory access router, default parameters.
// Assumes the far-side model answers data tags; instruction tags mirror that lookup.
`timescale 1ns/1ps
`include "lmar_defs.vh"
module lmar_router_test;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_rready, fetch_valid, ls_valid, ls_store, ls_word, acc_seen;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, fetch_addr, ls_addr, seed;
  logic [3:0]  delay;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire         refill_done, refill_req, replay, replay_next, prot_fault, fetch_fault, dc_wr_dirty;
  wire [1:0]   s_axi_bresp, s_axi_rresp;
  wire [31:0]  s_axi_rdata, refill_addr;
  wire [91:0]  dc_tag_rd;
  wire [3:0]   dc_tag_vld, ic_way_hit, dc_way_hit;
  wire [2:0]   fetch_target, ls_target;
  wire [5:0]   ic_index, dc_index;
  integer      error_cnt, samples_checked, i;
  logic [33:0] rq[$];
  logic [1:0]  bq[$];
  logic [21:0] aq[$], q;
  lmar_router i_lmar_router (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .fetch_valid, .fetch_addr, .ls_valid, .ls_store, .ls_word,
    .ls_addr, .ic_tag_rd({dc_tag_rd[88:69], dc_tag_rd[65:46], dc_tag_rd[42:23],
    dc_tag_rd[19:0]}), .ic_tag_vld(dc_tag_vld), .dc_tag_rd, .dc_tag_vld, .refill_done,
    .fetch_target, .ls_target, .ic_index, .dc_index, .ic_way_hit, .dc_way_hit, .dc_wr_dirty,
    .refill_req, .refill_addr, .replay, .replay_next, .prot_fault, .fetch_fault);
  lmar_far_model i_lmar_far_model (.aclk, .aresetn, .ls_addr, .refill_req, .refill_addr,
    .delay, .dc_tag_rd, .dc_tag_vld, .refill_done);
  function automatic [31:0] xs(input [31:0] v);
    logic [31:0] t;
    begin
      t = v ^ (v << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  task chk(input string nm, input [33:0] e, input [33:0] s, input [33:0] m);
    begin
      samples_checked = samples_checked + 1;
      if ((s & m) !== (e & m)) begin
        error_cnt = error_cnt + 1;
        $display("CHECK FAILED %0s expected %h seen %h", nm, e, s);
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] d, input [1:0] r);
    begin
      bq.push_back(r);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      @(posedge aclk);
      while (s_axi_awvalid || s_axi_wvalid || !s_axi_bvalid) begin
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
        @(posedge aclk);
      end
      s_axi_bready <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, input [33:0] e);
    begin
      rq.push_back(e);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      @(posedge aclk);
      while (!s_axi_arready) @(posedge aclk);
      s_axi_arvalid <= 1'b0;
      while (!s_axi_rvalid) @(posedge aclk);
      s_axi_rready <= 1'b0;
    end
  endtask
  // k is {fetch, store, word}; e and m are expected outputs and their mask
  task acc(input [2:0] k, input [31:0] a, input [10:0] e, input [10:0] m);
    begin
      @(posedge aclk);
      fetch_valid <= k[2];
      fetch_addr <= a;
      ls_valid <= 1'b1;
      ls_store <= k[1];
      ls_word <= k[0];
      ls_addr <= a;
      aq.push_back({m, e});
    end
  endtask
  task idle;
    begin
      @(posedge aclk);
      ls_valid <= 1'b0;
      fetch_valid <= 1'b0;
    end
  endtask
  task wait_refill;
    integer n;
    begin
      for (n = 0; n < 40 && refill_done !== 1'b1; n = n + 1) @(posedge aclk);
    end
  endtask
  task report_and_stop;
    begin
      $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
    end
  endtask
  always @(posedge aclk) begin
    acc_seen <= aresetn && (ls_valid || fetch_valid);
    if (s_axi_rvalid && s_axi_rready) chk("read", rq.pop_front(), {s_axi_rresp, s_axi_rdata}, '1);
    if (s_axi_bvalid && s_axi_bready) chk("bresp", bq.pop_front(), s_axi_bresp, 34'h3);
  end
  always @(negedge aclk) begin
    if (acc_seen === 1'b1) begin
      q = aq.pop_front();
      chk("access", q[10:0], {ls_target, replay, replay_next, prot_fault, fetch_fault,
          refill_req, dc_wr_dirty, dc_way_hit[1:0]}, q[21:11]);
    end
  end
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  // Run needs well under 2000 cycles; 20000 means a hang
  initial begin
    #2000000;
    error_cnt = error_cnt + 1;
    report_and_stop;
  end
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {fetch_valid, ls_valid, ls_store, ls_word} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, fetch_addr, ls_addr} = '0;
    delay = 4'h8;
    seed = 32'h0000_0037;
    error_cnt = 0;
    samples_checked = 0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`LMAR_REG_REGION, {2'h0, `LMAR_REGION_RESET});
    rd(`LMAR_REG_CTRL, {2'h0, `LMAR_CTRL_RESET});
    rd(8'h20, {`LMAR_RESP_SLVERR, 32'h0});
    wr(8'h20, 32'h5, `LMAR_RESP_SLVERR);
    wr(`LMAR_REG_STATUS, 32'hf, `LMAR_RESP_OK);
    $display("test registers done");
    for (i = 0; i < 4; i = i + 1) begin
      seed = xs(seed);
      acc(3'b001, 32'h3ff0_0000 | (seed & 32'h0000_fffc), {3'h3, 8'h00}, 11'h7ff);
      acc(3'b001, 32'h3fd0_0000 | (seed & 32'h000f_fffc), {3'h5, 8'h00}, 11'h7ff);
      acc(3'b001, 32'h6000_0000 | (seed & 32'h00ff_fffc), {3'h0, 8'h00}, 11'h7ff);
      acc(3'b001, 32'h4000_0000 | (seed & 32'h0000_fffc), {3'h1, 8'h80}, 11'h7ff);
      acc(3'b011, 32'h4000_0000 | (seed & 32'h0000_fffc), {3'h1, 8'h40}, 11'h7ff);
    end
    idle;
    $display("test targets done");
    for (i = 0; i < 8; i = i + 1) begin
      wr(`LMAR_REG_REGION, `LMAR_REGION_RESET & ~(32'h1 << (4 * i)), `LMAR_RESP_OK);
      acc(3'b100, {i[2:0], 29'h0100_0000}, 11'h030, 11'h030);
      idle;
    end
    rd(`LMAR_REG_FAULT, {2'h0, 32'he100_0000});
    rd(`LMAR_REG_COUNT, {2'h0, 32'h0008_0000});
    rd(`LMAR_REG_STATUS, {2'h0, 32'h0000_0008});
    $display("test protection done");
    wr(`LMAR_REG_REGION, 32'h1111_1117, `LMAR_RESP_OK);
    wr(`LMAR_REG_CTRL, 32'h3, `LMAR_RESP_OK);
    rd(`LMAR_REG_REGION, {2'h0, 32'h1111_1117});
    acc(3'b001, 32'h0000_2040, {3'h6, 8'h88}, 11'h7ff);
    acc(3'b001, 32'h0000_3080, {3'h6, 8'h80}, 11'h7ff);
    idle;
    wait_refill;
    acc(3'b001, 32'h0000_2040, {3'h6, 8'h01}, 11'h7ff);
    acc(3'b101, 32'h0000_2040, {3'h6, 8'h01}, 11'h7ff);
    acc(3'b011, 32'h0000_2044, {3'h6, 8'h05}, 11'h7ff);
    acc(3'b011, 32'h0000_5040, {3'h6, 8'h00}, 11'h7ff);
    delay <= 4'h0;
    acc(3'b001, 32'h0000_3080, {3'h6, 8'h88}, 11'h7ff);
    idle;
    wait_refill;
    acc(3'b001, 32'h0000_3080, {3'h6, 8'h02}, 11'h7ff);
    idle;
    rd(`LMAR_REG_COUNT, {2'h0, 32'h0000_0002});
    $display("test cache done");
    repeat (3) @(posedge aclk);
    error_cnt = error_cnt + aq.size() + rq.size() + bq.size();
    report_and_stop;
  end
endmodule // lmar_router_test
bind lmar_router lmar_monitor #(.TAG_W(TAG_W), .IDX_W(IDX_W), .IRAM_BASE(IRAM_BASE),
  .IRAM_MASK(IRAM_MASK)) i_lmar_monitor (.aclk, .aresetn, .fetch_valid, .fetch_addr, .ls_valid,
  .ls_store, .ls_word, .ls_addr, .dc_tag_rd, .dc_tag_vld, .ls_target, .ic_index, .dc_index,
  .dc_way_hit, .refill_req, .refill_addr, .replay, .replay_next, .prot_fault, .fetch_fault,
  .ic_tag_rd, .ic_tag_vld, .fetch_target, .ic_way_hit);
